// ### ncd_top.sv
module ncd_top
   import ncd_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // Modulator and sync pins
   input  wire logic [4:0] adc_data,
   input  wire logic       sysref,
   // Register port
   input  wire logic       init_start,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_rd_valid,
   output logic            init_busy,
   // Baseband stream
   output ncd_pkg::ncd_iq_t iq_data,
   output logic            iq_valid,
   input  wire logic       iq_ready,
   output logic            buf_space,
   output logic            overrun
);
   import ncd_pkg::*;

   typedef struct packed {
      logic [7:0]            dec_cfg;
      logic [7:0]            coarse;
      logic [7:0]            fine;
      logic [7:0]            cpre;
      logic [7:0]            fpre_lo;
      logic [7:0]            fpre_hi;
      logic [15:0]           adc_mhz;
      logic [15:0]           if_mhz;
      logic [7:0]            rdata;
      logic                  rvalid;
      logic                  overrun;
      logic                  busy;
      logic [4:0]            adc_s1;
      logic [4:0]            adc_s2;
      logic                  sys_s1;
      logic                  sys_s2;
      logic                  sys_s3;
      ncd_init_t             ist;
      logic [32:0]           rem;
      logic [31:0]           quo;
      logic [5:0]            icnt;
      logic [7:0]            cq;
      logic [5:0]            ph1;
      logic [9:0]            ph2;
      logic [1:0][12:0]      m1;
      logic                  m1_v;
      logic [1:0][14:0]      acc;
      logic [1:0]            cnt1;
      logic [1:0][14:0]      s1;
      logic                  s1_v;
      logic [1:0][17:0]      m2;
      logic                  m2_v;
      logic [2:0][1:0][17:0] x1;
      logic [2:0][1:0][17:0] x2;
      logic [2:0][1:0][17:0] y;
      logic [2:0]            hph;
      logic [2:0]            yv;
   } ncd_state_t;

   ncd_state_t            s;
   ncd_state_t            n;
   logic [2:0]            sel;
   logic                  sel_ok;
   logic                  d1_is3;
   logic                  use4;
   logic                  sys_edge;
   logic                  restart;
   logic [9:0]            fine_ext;
   logic [7:0]            fine_calc;
   logic [31:0]           divisor;
   logic [31:0]           dvd_c;
   logic [31:0]           dvd_f;
   logic [32:0]           div_t;
   logic                  div_ge;
   logic signed [4:0]     adc_x;
   logic signed [7:0]     c1;
   logic signed [7:0]     s1n;
   logic signed [7:0]     c2;
   logic signed [7:0]     s2n;
   logic signed [12:0]    p1i;
   logic signed [12:0]    p1q;
   logic signed [14:0]    a2;
   logic signed [14:0]    b2;
   logic signed [23:0]    p2i;
   logic signed [23:0]    p2q;
   logic [2:0][1:0][17:0] hb_in;
   logic [2:0]            hb_v;
   logic                  fin_v;
   ncd_iq_t               fin;
   logic                  buf_ready;

   // Quarter-wave cosine, amplitude 127, 64 points per cycle
   function automatic logic signed [7:0] cos_lut(input logic [5:0] ph);
      logic [4:0] idx;
      logic [7:0] mag;
      idx = ph[4] ? (5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
      case (idx)
         5'h00: mag = 8'h7F;
         5'h01: mag = 8'h7E;
         5'h02: mag = 8'h7D;
         5'h03: mag = 8'h7A;
         5'h04: mag = 8'h75;
         5'h05: mag = 8'h70;
         5'h06: mag = 8'h6A;
         5'h07: mag = 8'h62;
         5'h08: mag = 8'h5A;
         5'h09: mag = 8'h51;
         5'h0A: mag = 8'h47;
         5'h0B: mag = 8'h3C;
         5'h0C: mag = 8'h31;
         5'h0D: mag = 8'h25;
         5'h0E: mag = 8'h19;
         5'h0F: mag = 8'h0C;
         default: mag = 8'h00;
      endcase
      cos_lut = (ph[5] ^ ph[4]) ? -mag : mag;
   endfunction

   assign sel      = s.dec_cfg[DEC_SEL_MSB:DEC_SEL_LSB];
   assign sel_ok   = (sel >= DEC_SEL_32) && (sel <= DEC_SEL_12);
   assign d1_is3   = (sel == DEC_SEL_24) || (sel == DEC_SEL_12);
   assign use4     = (sel == DEC_SEL_32) || (sel == DEC_SEL_24);
   assign sys_edge = s.sys_s2 && !s.sys_s3;
   // Restarting the decimation stages keeps latency repeatable per setting
   assign restart  = sys_edge || (reg_wr_en && reg_addr == ADDR_DEC_CFG);
   assign fine_ext = {{2{s.fine[7]}}, s.fine};

   // Rounded divisions: quotient of (2*K*IF + ADC) by 2*ADC
   assign divisor = {15'h0000, s.adc_mhz, 1'b0};
   assign dvd_c   = {9'h000, s.if_mhz, 7'h00} + {16'h0000, s.adc_mhz};
   assign dvd_f   = (d1_is3 ? {4'h0, s.if_mhz, 12'h000}
                            + {5'h00, s.if_mhz, 11'h000}
                            : {3'h0, s.if_mhz, 13'h0000})
                    + {16'h0000, s.adc_mhz};
   assign div_t   = {s.rem[31:0], s.quo[31]};
   assign div_ge  = div_t >= {1'b0, divisor};
   // round(M*r) minus coarse*M/64 equals round of the residual
   assign fine_calc = s.quo[7:0] - (d1_is3
                      ? {s.cq[2:0], 5'h00} + {s.cq[3:0], 4'h0}
                      : {s.cq[1:0], 6'h00});

   // Mixers multiply by cos minus j sin
   assign adc_x = s.adc_s2;
   assign c1    = cos_lut(s.ph1);
   assign s1n   = cos_lut(s.ph1 - NCO_QUARTER);
   assign p1i   = adc_x * c1;
   assign p1q   = -(adc_x * s1n);
   assign a2    = s.s1[0];
   assign b2    = s.s1[1];
   assign c2    = cos_lut(s.ph2[9:4]);
   assign s2n   = cos_lut(s.ph2[9:4] - NCO_QUARTER);
   assign p2i   = a2 * c2 + b2 * s2n;
   assign p2q   = b2 * c2 - a2 * s2n;

   assign hb_in = {s.y[1], s.y[0], s.m2};
   assign hb_v  = {s.yv[1], s.yv[0], s.m2_v};
   assign fin_v = sel_ok && (use4 ? s.yv[2] : s.yv[1]);
   assign fin.i = use4 ? s.y[2][0][17:2] : s.y[1][0][17:2];
   assign fin.q = use4 ? s.y[2][1][17:2] : s.y[1][1][17:2];

   always_comb
   begin
      logic [19:0] hb_sum;
      hb_sum = '0;
      n = s;
      n.rvalid = 1'b0;
      n.adc_s1 = adc_data;
      n.adc_s2 = s.adc_s1;
      n.sys_s1 = sysref;
      n.sys_s2 = s.sys_s1;
      n.sys_s3 = s.sys_s2;
      if (reg_wr_en)
      begin
         case (reg_addr)
            ADDR_ADC_LO:  n.adc_mhz[7:0]  = reg_wdata;
            ADDR_ADC_HI:  n.adc_mhz[15:8] = reg_wdata;
            ADDR_IF_LO:   n.if_mhz[7:0]   = reg_wdata;
            ADDR_IF_HI:   n.if_mhz[15:8]  = reg_wdata;
            ADDR_DEC_CFG: n.dec_cfg       = reg_wdata;
            ADDR_COARSE:  n.coarse        = reg_wdata;
            ADDR_FINE:    n.fine          = reg_wdata;
            ADDR_CPRE:    n.cpre          = reg_wdata;
            ADDR_FPRE_LO: n.fpre_lo       = reg_wdata;
            ADDR_FPRE_HI: n.fpre_hi       = reg_wdata;
            ADDR_STATUS:  n.overrun = s.overrun && !reg_wdata[STAT_OVR];
            default:      n.overrun = s.overrun;
         endcase
      end
      if (reg_rd_en)
      begin
         n.rvalid = 1'b1;
         case (reg_addr)
            ADDR_ADC_LO:  n.rdata = s.adc_mhz[7:0];
            ADDR_ADC_HI:  n.rdata = s.adc_mhz[15:8];
            ADDR_IF_LO:   n.rdata = s.if_mhz[7:0];
            ADDR_IF_HI:   n.rdata = s.if_mhz[15:8];
            ADDR_DEC_CFG: n.rdata = s.dec_cfg;
            ADDR_COARSE:  n.rdata = s.coarse;
            ADDR_FINE:    n.rdata = s.fine;
            ADDR_CPRE:    n.rdata = s.cpre;
            ADDR_FPRE_LO: n.rdata = s.fpre_lo;
            ADDR_FPRE_HI: n.rdata = s.fpre_hi;
            ADDR_STATUS:  n.rdata = {6'h00, s.overrun, s.busy};
            default:      n.rdata = 8'h00;
         endcase
      end

      // Tuning word calculation, two serial divisions
      case (s.ist)
         NCD_IDLE:
         begin
            if (init_start)
            begin
               n.ist  = NCD_DIV_C;
               n.rem  = '0;
               n.quo  = dvd_c;
               n.icnt = '0;
            end
         end
         NCD_DIV_C, NCD_DIV_F:
         begin
            n.rem  = div_ge ? div_t - {1'b0, divisor} : div_t;
            n.quo  = {s.quo[30:0], div_ge};
            n.icnt = s.icnt + 6'h01;
            if (s.icnt == DIV_LAST)
            begin
               if (s.ist == NCD_DIV_C)
               begin
                  n.cq   = n.quo[7:0];
                  n.rem  = '0;
                  n.quo  = dvd_f;
                  n.icnt = '0;
                  n.ist  = NCD_DIV_F;
               end
               else
                  n.ist = NCD_STORE;
            end
         end
         NCD_STORE:
         begin
            n.coarse = {2'h0, s.cq[5:0]};
            n.fine   = fine_calc;
            n.ist    = NCD_IDLE;
         end
         default: n.ist = NCD_IDLE;
      endcase
      n.busy = (n.ist != NCD_IDLE);

      // Oscillators; frequency is the sum of both words
      if (sys_edge)
      begin
         n.ph1 = s.cpre[5:0];
         n.ph2 = {s.fpre_hi[1:0], s.fpre_lo};
      end
      else
      begin
         n.ph1 = s.ph1 + s.coarse[5:0];
         if (s.s1_v)
            n.ph2 = s.ph2 + fine_ext;
      end

      n.m1   = {p1q, p1i};
      n.m1_v = sel_ok;

      // First stage: symmetric boxcar over 3 or 4 samples
      n.s1_v = 1'b0;
      if (restart)
      begin
         n.acc  = '0;
         n.cnt1 = '0;
      end
      else if (s.m1_v)
      begin
         for (int c = 0; c < 2; c++)
            n.acc[c] = s.acc[c] + {{2{s.m1[c][12]}}, s.m1[c]};
         n.cnt1 = s.cnt1 + 2'h1;
         if (s.cnt1 == (d1_is3 ? D1_LAST_BY3 : D1_LAST_BY4))
         begin
            n.s1   = n.acc;
            n.acc  = '0;
            n.cnt1 = '0;
            n.s1_v = 1'b1;
         end
      end

      // A word in flight at a restart would shift the halving phases
      n.m2_v = s.s1_v && !restart;
      if (s.s1_v)
         n.m2 = {p2q[23:6], p2i[23:6]};

      // Halving stages, taps 1 2 1 alike on I and Q
      for (int k = 0; k < HB_STAGES; k++)
      begin
         n.yv[k] = 1'b0;
         if (restart)
         begin
            n.hph[k] = 1'b0;
            n.x1[k]  = '0;
            n.x2[k]  = '0;
         end
         else if (hb_v[k])
         begin
            n.hph[k] = !s.hph[k];
            n.yv[k]  = s.hph[k];
            for (int c = 0; c < 2; c++)
            begin
               n.x1[k][c] = hb_in[k][c];
               n.x2[k][c] = s.x1[k][c];
               hb_sum = {{2{hb_in[k][c][17]}}, hb_in[k][c]}
                      + {s.x1[k][c][17], s.x1[k][c], 1'b0}
                      + {{2{s.x2[k][c][17]}}, s.x2[k][c]};
               if (s.hph[k])
                  n.y[k][c] = hb_sum[19:2];
            end
         end
      end

      // A full buffer drops the word; the sticky flag wins over a clear
      if (fin_v && !buf_ready)
         n.overrun = 1'b1;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s         <= '0;
         s.dec_cfg <= RST_DEC_CFG;
         s.adc_mhz <= RST_ADC_MHZ;
         s.if_mhz  <= RST_IF_MHZ;
      end
      else
         s <= n;
   end

   ncd_buf u_buf (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_data   (fin),
      .in_valid  (fin_v),
      .in_ready  (buf_ready),
      .out_data  (iq_data),
      .out_valid (iq_valid),
      .out_ready (iq_ready)
   );

   assign reg_rdata    = s.rdata;
   assign reg_rd_valid = s.rvalid;
   assign init_busy    = s.busy;
   assign buf_space    = buf_ready;
   assign overrun      = s.overrun;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_coarse_step: assert property (
      !sys_edge |=> s.ph1 == $past(s.ph1) + $past(s.coarse[5:0]))
      else $error("coarse phase step wrong");
   a_coarse_preset: assert property (
      sys_edge |=> s.ph1 == $past(s.cpre[5:0]))
      else $error("coarse preset not loaded");
   a_fine_preset: assert property (
      sys_edge |=> s.ph2 == $past({s.fpre_hi[1:0], s.fpre_lo}))
      else $error("fine preset not loaded");
   a_fine_step: assert property (
      s.s1_v && !sys_edge |=> s.ph2 == $past(s.ph2) + $past(fine_ext))
      else $error("fine phase step wrong");
   a_stage1_by3: assert property (
      s.s1_v && d1_is3 |=> !s.s1_v [*2])
      else $error("first stage faster than one in three");
   a_stage1_by4: assert property (
      s.s1_v && !d1_is3 |=> !s.s1_v [*3])
      else $error("first stage faster than one in four");
   a_stage3_gap: assert property (
      s.yv[1] |=> !s.yv[1] [*8])
      else $error("third stage output too dense");
   a_reserved_idle: assert property (
      !sel_ok [*3] |-> !s.m1_v && !s.s1_v && !fin_v)
      else $error("reserved select produced data");
   a_init_time: assert property (
      $rose(s.busy) |-> ##64 s.busy ##1 !s.busy)
      else $error("initialization length wrong");
   a_init_store: assert property (
      s.ist == NCD_STORE |=> s.coarse == {2'h0, $past(s.cq[5:0])})
      else $error("coarse word not stored");
   a_overrun_set: assert property (
      fin_v && !buf_ready |=> s.overrun)
      else $error("lost word not flagged");

   c_sync_load: cover property (sys_edge);
   c_init_done: cover property ($fell(s.busy));
   c_out_by12: cover property (fin_v && sel == DEC_SEL_12 && buf_ready);
   c_overrun: cover property (fin_v && !buf_ready);
endmodule

// ### ncd_pkg.sv
package ncd_pkg;
   // Register map
   localparam logic [9:0] ADDR_ADC_LO   = 10'h100;
   localparam logic [9:0] ADDR_ADC_HI   = 10'h101;
   localparam logic [9:0] ADDR_IF_LO    = 10'h102;
   localparam logic [9:0] ADDR_IF_HI    = 10'h103;
   localparam logic [9:0] ADDR_DEC_CFG  = 10'h140;
   localparam logic [9:0] ADDR_COARSE   = 10'h141;
   localparam logic [9:0] ADDR_FINE     = 10'h142;
   localparam logic [9:0] ADDR_CPRE     = 10'h143;
   localparam logic [9:0] ADDR_FPRE_LO  = 10'h144;
   localparam logic [9:0] ADDR_FPRE_HI  = 10'h145;
   localparam logic [9:0] ADDR_STATUS   = 10'h146;
   // Reset values
   localparam logic [15:0] RST_ADC_MHZ  = 16'h0C80;
   localparam logic [15:0] RST_IF_MHZ   = 16'h008C;
   localparam logic [7:0]  RST_DEC_CFG  = 8'h01;
   // Fields
   localparam int DEC_SEL_LSB  = 0;
   localparam int DEC_SEL_MSB  = 2;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_OVR     = 1;
   // Decimation select codes
   localparam logic [2:0] DEC_SEL_32 = 3'h1;
   localparam logic [2:0] DEC_SEL_24 = 3'h2;
   localparam logic [2:0] DEC_SEL_16 = 3'h3;
   localparam logic [2:0] DEC_SEL_12 = 3'h4;
   // Timing counts
   localparam logic [1:0] D1_LAST_BY3  = 2'h2;
   localparam logic [1:0] D1_LAST_BY4  = 2'h3;
   localparam logic [5:0] DIV_LAST     = 6'h1F;
   localparam logic [5:0] NCO_QUARTER  = 6'h10;
   localparam int         HB_STAGES    = 3;

   typedef enum logic [1:0] {
      NCD_IDLE   = 2'b00,
      NCD_DIV_C  = 2'b01,
      NCD_DIV_F  = 2'b10,
      NCD_STORE  = 2'b11
   } ncd_init_t;

   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } ncd_iq_t;
endpackage

// ### ncd_buf.sv
module ncd_buf
   import ncd_pkg::*;
(
   // Clock and reset
   input  wire logic    mclk,
   input  wire logic    reset_n,
   // Fill side
   input  wire ncd_iq_t in_data,
   input  wire logic    in_valid,
   output logic         in_ready,
   // Drain side
   output ncd_iq_t      out_data,
   output logic         out_valid,
   input  wire logic    out_ready
);
   typedef struct packed {
      ncd_iq_t head;
      logic    head_v;
      ncd_iq_t spare;
      logic    spare_v;
   } ncd_buf_t;

   ncd_buf_t s;
   ncd_buf_t n;

   // Ready depends only on the spare slot, so it is a plain flop
   always_comb
   begin
      n = s;
      if (s.head_v && out_ready)
      begin
         n.head_v = 1'b0;
         if (s.spare_v)
         begin
            n.head    = s.spare;
            n.head_v  = 1'b1;
            n.spare_v = 1'b0;
         end
      end
      if (in_valid && !s.spare_v)
      begin
         if (!n.head_v)
         begin
            n.head   = in_data;
            n.head_v = 1'b1;
         end
         else
         begin
            n.spare   = in_data;
            n.spare_v = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         s <= '0;
      else
         s <= n;
   end

   assign in_ready  = !s.spare_v;
   assign out_data  = s.head;
   assign out_valid = s.head_v;
endmodule

// ### ncd_sink.sv
module ncd_sink
   import ncd_pkg::*;
(
   // Clock and reset
   input  wire logic    mclk,
   input  wire logic    reset_n,
   // Stream from the block
   input  wire ncd_iq_t iq_data,
   input  wire logic    iq_valid,
   output logic         iq_ready,
   // Bench control and observation
   input  wire logic    stall,
   output int           acc_cnt,
   output int           gap,
   output ncd_iq_t      last_word
);
   timeunit 1ns;
   timeprecision 100ps;
   int since;
   // Ready moves off the sampling edge, like a real receiver front end
   always @(negedge mclk or negedge reset_n)
      if (!reset_n)
         iq_ready <= 1'b0;
      else
         iq_ready <= !stall;
   // Gap counts clock edges between two accepted words
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_cnt <= 0;
         gap <= 0;
         since <= 0;
      end
      else if (iq_valid === 1'b1 && iq_ready)
      begin
         acc_cnt <= acc_cnt + 1;
         gap <= since;
         since <= 1;
         last_word <= iq_data;
      end
      else
         since <= since + 1;
   end
endmodule

// ### ncd_tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ncd_pkg::*;
   logic        mclk = 1'b0, reset_n = 1'b0, sysref = 1'b0, stall = 1'b0;
   logic        init_start = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [4:0]  adc_data = 5'h00;
   logic [9:0]  reg_addr = 10'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        reg_rd_valid, init_busy, iq_valid, iq_ready;
   logic        buf_space, overrun;
   ncd_iq_t     iq_data, last_word;
   int          acc_cnt, gap, error_cnt = 0, comparisons = 0, cyc = 0;
   logic [31:0] seed = 32'hac0f_1f23, aseed = 32'hac0f_1f23;
   logic [2:0]  fact_res [4] = '{3'h0, 3'h5, 3'h6, 3'h7};

   ncd_top dut (.mclk(mclk), .reset_n(reset_n), .adc_data(adc_data),
      .sysref(sysref), .init_start(init_start), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .init_busy(init_busy), .iq_data(iq_data), .iq_valid(iq_valid),
      .iq_ready(iq_ready), .buf_space(buf_space), .overrun(overrun));
   ncd_sink sink (.mclk(mclk), .reset_n(reset_n), .iq_data(iq_data),
      .iq_valid(iq_valid), .iq_ready(iq_ready), .stall(stall),
      .acc_cnt(acc_cnt), .gap(gap), .last_word(last_word));

   always #2.5 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int fact(input logic [2:0] s);
      return (s == 3'h1) ? 32 : (s == 3'h2) ? 24 : (s == 3'h3) ? 16 :
             (s == 3'h4) ? 12 : 0;
   endfunction
   function automatic int ecoarse(input int adc, input int ifr);
      return (128 * ifr + adc) / (2 * adc);
   endfunction
   function automatic int efine(input int adc, ifr, input logic [2:0] s);
      int m;
      m = (s == 3'h2 || s == 3'h4) ? 3072 : 4096;
      return ((2 * m * ifr + adc) / (2 * adc) - ecoarse(adc, ifr) * m / 64)
             & 255;
   endfunction

   // Modulator samples change every cycle, off the sampling edge
   always @(negedge mclk)
   begin
      aseed = lfsr(aseed);
      adc_data <= aseed[4:0];
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Strobe lowered, then one idle cycle so the next call never
   // raises it again in the same time step
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      tick(1);
      reg_wr_en <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      tick(1);
      // The valid pulse stands for one cycle only, so look now
      chk("reg_rd_valid", 32'h0000_0001, {31'h0, reg_rd_valid});
      chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
      reg_rd_en <= 1'b0;
      tick(1);
   endtask
   task automatic run_init(input int adc, ifr, input logic [2:0] s);
      int n;
      n = 0;
      wr(ADDR_ADC_LO, adc[7:0]);
      wr(ADDR_ADC_HI, adc[15:8]);
      wr(ADDR_IF_LO, ifr[7:0]);
      wr(ADDR_IF_HI, ifr[15:8]);
      wr(ADDR_DEC_CFG, {5'h00, s});
      init_start <= 1'b1;
      tick(1);
      init_start <= 1'b0;
      repeat (100)
      begin
         if (init_busy === 1'b1)
            n++;
         tick(1);
      end
      chk("init_busy cycles", 32'd65, n);
      rd(ADDR_COARSE, 8'(ecoarse(adc, ifr)));
      rd(ADDR_FINE, 8'(efine(adc, ifr, s)));
   endtask
   // Cycles from a mode write to the next accepted word, then the gap
   task automatic rate(input logic [2:0] s, output int l);
      int c;
      wr(ADDR_DEC_CFG, {5'h00, s});
      // A word produced at the restart edge is still draining
      tick(2);
      c = acc_cnt;
      l = 3;
      while (acc_cnt == c && l < 400)
      begin
         tick(1);
         l++;
      end
      tick(150);
      chk("output gap", fact(s), gap);
   endtask

   initial
   begin
      int l0, l1, l2, c, adc, ifr;
      repeat (8) @(posedge mclk);
      chk("iq_valid in reset", 32'h0, {31'h0, iq_valid});
      chk("overrun in reset", 32'h0, {31'h0, overrun});
      @(negedge mclk);
      reset_n <= 1'b1;
      tick(2);
      rd(ADDR_DEC_CFG, RST_DEC_CFG);
      rd(ADDR_ADC_LO, RST_ADC_MHZ[7:0]);
      rd(ADDR_ADC_HI, RST_ADC_MHZ[15:8]);
      rd(ADDR_IF_LO, RST_IF_MHZ[7:0]);
      rd(ADDR_IF_HI, RST_IF_MHZ[15:8]);
      rd(10'h1ff, 8'h00);
      $display("test registers done");
      run_init(3200, 140, DEC_SEL_16);
      for (int i = 1; i < 5; i++)
      begin
         seed = lfsr(seed);
         adc = 2000 + int'(seed % 1201);
         seed = lfsr(seed);
         ifr = 70 + int'(seed % 381);
         run_init(adc, ifr, 3'(i));
      end
      $display("test tuning done");
      for (int s = 1; s < 5; s++)
      begin
         rate(3'(s), l0);
         rate(3'(s), l1);
         rate(3'(s), l2);
         chk("latency", l1, l2);
      end
      $display("test rates done");
      seed = lfsr(seed);
      wr(ADDR_CPRE, {2'h0, seed[5:0]});
      wr(ADDR_FPRE_LO, seed[15:8]);
      wr(ADDR_FPRE_HI, {6'h00, seed[17:16]});
      rd(ADDR_CPRE, {2'h0, seed[5:0]});
      rd(ADDR_FPRE_LO, seed[15:8]);
      rd(ADDR_FPRE_HI, {6'h00, seed[17:16]});
      sysref <= 1'b1;
      tick(4);
      sysref <= 1'b0;
      tick(200);
      chk("gap after sync", 32'd12, gap);
      $display("test sync done");
      stall <= 1'b1;
      tick(120);
      chk("iq_valid stalled", 32'h1, {31'h0, iq_valid});
      chk("buf_space full", 32'h0, {31'h0, buf_space});
      chk("overrun", 32'h1, {31'h0, overrun});
      rd(ADDR_STATUS, 8'h02);
      c = acc_cnt;
      stall <= 1'b0;
      tick(4);
      chk("drained words", 32'h1, {31'h0, acc_cnt >= c + 2});
      wr(ADDR_STATUS, 8'h02);
      tick(1);
      chk("overrun cleared", 32'h0, {31'h0, overrun});
      rd(ADDR_STATUS, 8'h00);
      $display("test buffer done");
      foreach (fact_res[k])
      begin
         wr(ADDR_DEC_CFG, {5'h00, fact_res[k]});
         tick(100);
         c = acc_cnt;
         tick(200);
         chk("reserved words", c, acc_cnt);
      end
      $display("test reserved done");
      give_verdict();
   end
endmodule
